// >>> hw/pin_function_pkg.sv
// Package: register map, field positions and carriers of the pin function block
`default_nettype none

package pin_function_pkg;

    // ********************************************************
    // Geometry
    // ********************************************************
    localparam int PORT_W = 8;
    localparam int NUM_PORTS = 5;
    localparam int FIX_W = 4;
    localparam int NUM_EXT_INT = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ********************************************************
    // Register indexes, byte address is four times the index
    // ********************************************************
    localparam logic [ADDR_W-1:0] IDX_PORT_DATA_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] IDX_FIX_SERIAL_DATA = 8'h05;
    localparam logic [ADDR_W-1:0] IDX_FIX_ANALOG_DATA = 8'h06;
    localparam logic [ADDR_W-1:0] IDX_PORT_DIR_BASE = 8'h07;
    localparam logic [ADDR_W-1:0] IDX_CONV_CTRL = 8'h29;
    localparam logic [ADDR_W-1:0] IDX_PERIPH_CTRL = 8'h2A;
    localparam logic [ADDR_W-1:0] IDX_INT_CTRL = 8'h30;
    localparam logic [ADDR_W-1:0] IDX_INT_STATUS = 8'h31;
    localparam logic [ADDR_W-1:0] IDX_INT_MASK = 8'h32;
    localparam logic [ADDR_W-1:0] IDX_INT_PIN_LEVEL = 8'h33;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CONV_POWER_ON_BIT = 5;
    localparam int SERIAL_ENABLE_BIT = 6;
    localparam int INT_LEVEL_LSB = 0;
    localparam int INT_ENABLE_LSB = 4;
    localparam int EXT_FIXED = 0;
    localparam int EXT_GP_ONE = 1;
    localparam int EXT_GP_TWO = 2;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [PORT_W-1:0] PORT_DIR_RST = 8'h00;
    localparam logic [PORT_W-1:0] PORT_LATCH_RST = 8'h00;
    localparam logic [NUM_EXT_INT-1:0] INT_VEC_RST = 3'h0;
    localparam logic [NUM_EXT_INT-1:0] INT_EN_RST = 3'h1;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic [NUM_EXT_INT-1:0] level_mode;
        logic [NUM_EXT_INT-1:0] enable;
    } int_cfg_t;

    typedef struct packed {
        logic [FIX_W-1:0] out;
        logic [FIX_W-1:0] oe;
    } fix_drive_t;

endpackage

`default_nettype wire

// >>> hw/ext_int_detect.sv
// External interrupt pin synchroniser with edge or edge-plus-level request
`default_nettype none

module ext_int_detect
(
    input wire logic ref_clk_i,    // Bus clock
    input wire logic reset_n_i,    // Async reset, active low
    input wire logic pin_n_i,      // Interrupt pin, active low
    input wire logic level_mode_i, // 1: falling edge plus low level
    output logic level_o,          // Synchronised pin level
    output logic request_o         // Request this cycle
);

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic fall;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r <= 1'b1;
        end
        else
        begin
            sync1_r <= pin_n_i;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign fall = prev_r & ~sync2_r;
    assign level_o = sync2_r;
    // Held low in level mode keeps requesting every cycle
    assign request_o = fall | (level_mode_i & ~sync2_r);

endmodule // ext_int_detect

`default_nettype wire

// >>> hw/pin_function_select.sv
// Pin function select: parallel ports, fixed ports, external interrupts, timer pins
`default_nettype none

module pin_function_select
    import pin_function_pkg::*;
#(
    parameter int PW = PORT_W,
    parameter int NP = NUM_PORTS
)
(
    input wire logic ref_clk_i,                       // 25 MHz bus clock
    input wire logic reset_n_i,                       // Async reset, active low
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address,            // Byte address
    input wire logic read,                            // Read request
    input wire logic write,                           // Write request
    input wire logic [DATA_W-1:0] writedata,          // Write data
    output logic [DATA_W-1:0] readdata,               // Read data
    output logic waitrequest,                         // Stall
    output logic irq_o,                               // Interrupt, level
    // Bidirectional ports
    input wire logic [NP*PW-1:0] port_pin_i,          // Pin levels
    output logic [NP*PW-1:0] port_pin_o,              // Output latches
    output logic [NP*PW-1:0] port_pin_oe_o,           // Drive enables
    // Fixed serial port
    input wire logic [FIX_W-1:0] fixed_port_serial_lines_i,  // Pin levels
    output logic [FIX_W-1:0] fixed_port_serial_lines_o,      // Pin drive
    output logic [FIX_W-1:0] fixed_port_serial_lines_oe_o,   // Drive enable
    input wire fix_drive_t serial_drive_i,            // From serial core
    output logic [FIX_W-1:0] serial_lines_in_o,       // To serial core
    output logic serial_peripheral_enable_o,          // Serial enabled
    // Fixed analog port
    input wire logic [FIX_W-1:0] fixed_port_analog_lines_i,  // Digital levels
    output logic converter_power_on_o,                // Converter power on
    // Interrupt pins
    input wire logic fixed_irq_n_i,                   // Fixed interrupt pin
    input wire logic gp_interrupt_one_n_i,            // General interrupt one
    input wire logic gp_interrupt_two_n_i,            // General interrupt two
    // Timer pins
    input wire logic capture_input_pin_i,             // Capture pin
    output logic capture_to_timer_o,                  // Synced capture level
    input wire logic timer_compare_i,                 // Timer compare result
    output logic compare_output_pin_o                 // Compare pin
);

    // ********************************************************
    // Bus slave
    // ********************************************************
    logic wait_r;
    logic [DATA_W-1:0] rdata_r;
    logic [ADDR_W-1:0] idx;
    logic req;
    logic do_wr;
    logic do_rd;
    logic [PW-1:0] wbyte;
    logic [PW-1:0] rd_byte;

    assign idx = {2'h0, address[ADDR_W-1:2]};
    assign req = read | write;
    // One wait cycle so read data is a register
    assign do_wr = write & ~wait_r;
    assign do_rd = read & ~wait_r;
    assign wbyte = writedata[PW-1:0];

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            wait_r <= ~(req & wait_r);
            if (read & wait_r)
            begin
                rdata_r <= {{(DATA_W-PW){1'b0}}, rd_byte};
            end
        end
    end

    assign waitrequest = wait_r;
    assign readdata = rdata_r;

    // ********************************************************
    // Bidirectional ports
    // ********************************************************
    logic [NP*PW-1:0] dir_r;
    logic [NP*PW-1:0] latch_r;
    logic [NP*PW-1:0] pin_s1_r;
    logic [NP*PW-1:0] pin_s2_r;
    logic [NP*PW-1:0] port_view;
    logic [NP-1:0] hit_data;
    logic [NP-1:0] hit_dir;

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++)
        begin : g_port
            assign hit_data[gp] = (idx == IDX_PORT_DATA_BASE + ADDR_W'(gp));
            assign hit_dir[gp] = (idx == IDX_PORT_DIR_BASE + ADDR_W'(gp));

            // Latch writes land in any direction; pin only sees them when output
            always_ff @(posedge ref_clk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    dir_r[gp*PW +: PW] <= PORT_DIR_RST;
                    latch_r[gp*PW +: PW] <= PORT_LATCH_RST;
                end
                else
                begin
                    if (do_wr & hit_dir[gp])
                    begin
                        dir_r[gp*PW +: PW] <= wbyte;
                    end
                    if (do_wr & hit_data[gp])
                    begin
                        latch_r[gp*PW +: PW] <= wbyte;
                    end
                end
            end

            // Output lines read back the latch, not the pin
            assign port_view[gp*PW +: PW] =
                (dir_r[gp*PW +: PW] & latch_r[gp*PW +: PW]) |
                (~dir_r[gp*PW +: PW] & pin_s2_r[gp*PW +: PW]);
        end
    endgenerate

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end
        else
        begin
            pin_s1_r <= port_pin_i;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Fifth port is kept whole; small package relies on software
    // setting it to output to stop floating inputs leaking
    assign port_pin_o = latch_r;
    assign port_pin_oe_o = dir_r;

    // ********************************************************
    // Fixed ports
    // ********************************************************
    logic serial_en_r;
    logic conv_on_r;
    logic [FIX_W-1:0] ser_s1_r;
    logic [FIX_W-1:0] ser_s2_r;
    logic [FIX_W-1:0] ana_s1_r;
    logic [FIX_W-1:0] ana_s2_r;
    fix_drive_t ser_drv_r;
    fix_drive_t ser_drv_nxt;
    logic hit_periph;
    logic hit_conv;

    assign hit_periph = (idx == IDX_PERIPH_CTRL);
    assign hit_conv = (idx == IDX_CONV_CTRL);
    // Serial core only owns the drivers while enabled
    assign ser_drv_nxt.out = serial_en_r ? serial_drive_i.out : '0;
    assign ser_drv_nxt.oe = serial_en_r ? serial_drive_i.oe : '0;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            serial_en_r <= 1'b0;
            conv_on_r <= 1'b0;
            ser_drv_r <= '0;
            ser_s1_r <= '0;
            ser_s2_r <= '0;
            ana_s1_r <= '0;
            ana_s2_r <= '0;
        end
        else
        begin
            if (do_wr & hit_periph)
            begin
                serial_en_r <= wbyte[SERIAL_ENABLE_BIT];
            end
            if (do_wr & hit_conv)
            begin
                conv_on_r <= wbyte[CONV_POWER_ON_BIT];
            end
            ser_drv_r <= ser_drv_nxt;
            ser_s1_r <= fixed_port_serial_lines_i;
            ser_s2_r <= ser_s1_r;
            ana_s1_r <= fixed_port_analog_lines_i;
            ana_s2_r <= ana_s1_r;
        end
    end

    // Line order: 0 miso, 1 mosi, 2 clock, 3 select
    assign fixed_port_serial_lines_o = ser_drv_r.out;
    assign fixed_port_serial_lines_oe_o = ser_drv_r.oe;
    assign serial_lines_in_o = ser_s2_r;
    assign serial_peripheral_enable_o = serial_en_r;
    // Digital reads stay possible while converting, at a noise cost
    assign converter_power_on_o = conv_on_r;

    // ********************************************************
    // External interrupts
    // ********************************************************
    int_cfg_t int_cfg_r;
    logic [NUM_EXT_INT-1:0] int_stat_r;
    logic [NUM_EXT_INT-1:0] int_stat_nxt;
    logic [NUM_EXT_INT-1:0] int_mask_r;
    logic [NUM_EXT_INT-1:0] pin_level;
    logic [NUM_EXT_INT-1:0] pin_req;
    logic [NUM_EXT_INT-1:0] pin_n;
    logic [NUM_EXT_INT-1:0] int_set;
    logic [NUM_EXT_INT-1:0] stat_clr;
    logic irq_r;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;

    assign pin_n = {gp_interrupt_two_n_i, gp_interrupt_one_n_i, fixed_irq_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EXT_INT; gi++)
        begin : g_int
            ext_int_detect u_detect
            (
                .ref_clk_i(ref_clk_i),
                .reset_n_i(reset_n_i),
                .pin_n_i(pin_n[gi]),
                .level_mode_i(int_cfg_r.level_mode[gi]),
                .level_o(pin_level[gi]),
                .request_o(pin_req[gi])
            );
        end
    endgenerate

    assign hit_ctrl = (idx == IDX_INT_CTRL);
    assign hit_stat = (idx == IDX_INT_STATUS);
    assign hit_mask = (idx == IDX_INT_MASK);
    // Fixed source has no enable; its enable bit is held at one
    assign int_set = pin_req & int_cfg_r.enable;
    // Clear only what the read reported; a set arriving after the data was taken stays
    assign stat_clr = (do_rd & hit_stat) ? rdata_r[NUM_EXT_INT-1:0] : '0;
    // A new request wins over the clear made by the read
    assign int_stat_nxt = (int_stat_r & ~stat_clr) | int_set;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            int_cfg_r.level_mode <= INT_VEC_RST;
            int_cfg_r.enable <= INT_EN_RST;
            int_stat_r <= INT_VEC_RST;
            int_mask_r <= INT_VEC_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            if (do_wr & hit_ctrl)
            begin
                int_cfg_r.level_mode <= wbyte[INT_LEVEL_LSB +: NUM_EXT_INT];
                int_cfg_r.enable <= {wbyte[INT_ENABLE_LSB +: NUM_EXT_INT-1], 1'b1};
            end
            if (do_wr & hit_mask)
            begin
                int_mask_r <= wbyte[NUM_EXT_INT-1:0];
            end
            int_stat_r <= int_stat_nxt;
            irq_r <= |(int_stat_nxt & int_mask_r);
        end
    end

    assign irq_o = irq_r;

    // ********************************************************
    // Timer pins
    // ********************************************************
    logic cap_s1_r;
    logic cap_s2_r;
    logic cmp_r;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cap_s1_r <= 1'b0;
            cap_s2_r <= 1'b0;
            cmp_r <= 1'b0;
        end
        else
        begin
            cap_s1_r <= capture_input_pin_i;
            cap_s2_r <= cap_s1_r;
            cmp_r <= timer_compare_i;
        end
    end

    assign capture_to_timer_o = cap_s2_r;
    assign compare_output_pin_o = cmp_r;

    // ********************************************************
    // Read mux
    // ********************************************************
    logic [PW-1:0] rd_port;
    logic [PW-1:0] rd_ctrl;

    always_comb
    begin
        rd_port = '0;
        for (int p = 0; p < NP; p++)
        begin
            if (hit_data[p])
            begin
                rd_port = port_view[p*PW +: PW];
            end
            if (hit_dir[p])
            begin
                rd_port = dir_r[p*PW +: PW];
            end
        end
    end

    always_comb
    begin
        rd_ctrl = '0;
        case (idx)
            IDX_FIX_SERIAL_DATA: rd_ctrl = {4'h0, ser_s2_r};
            IDX_FIX_ANALOG_DATA: rd_ctrl = {4'h0, ana_s2_r};
            IDX_PERIPH_CTRL: rd_ctrl = 8'(serial_en_r) << SERIAL_ENABLE_BIT;
            IDX_CONV_CTRL: rd_ctrl = 8'(conv_on_r) << CONV_POWER_ON_BIT;
            IDX_INT_CTRL: rd_ctrl = {2'h0, int_cfg_r.enable[2:1], 1'b0, int_cfg_r.level_mode};
            IDX_INT_STATUS: rd_ctrl = {5'h00, int_stat_r};
            IDX_INT_MASK: rd_ctrl = {5'h00, int_mask_r};
            IDX_INT_PIN_LEVEL: rd_ctrl = {5'h00, pin_level};
            default: rd_ctrl = '0;
        endcase
    end

    assign rd_byte = rd_port | rd_ctrl;

endmodule // pin_function_select

`default_nettype wire

// >>> dv/pin_function_select_properties.sv
// Checker: bus, port, serial, timer and interrupt properties of the pin function block
`default_nettype none

module pin_function_select_properties
    import pin_function_pkg::*;
#(
    parameter int PW = PORT_W,
    parameter int NP = NUM_PORTS
)
(
    input wire logic ref_clk_i,                           // Clock
    input wire logic reset_n_i,                           // Reset
    input wire logic read,                                // Read
    input wire logic write,                               // Write
    input wire logic waitrequest,                         // Stall
    input wire logic irq_o,                               // Interrupt
    input wire logic [NP*PW-1:0] port_pin_o,              // Latches
    input wire logic [NP*PW-1:0] port_pin_oe_o,           // Directions
    input wire logic [FIX_W-1:0] fixed_port_serial_lines_i,    // Pins
    input wire logic [FIX_W-1:0] fixed_port_serial_lines_o,    // Drive
    input wire logic [FIX_W-1:0] fixed_port_serial_lines_oe_o, // Enable
    input wire fix_drive_t serial_drive_i,                // Core drive
    input wire logic [FIX_W-1:0] serial_lines_in_o,       // To core
    input wire logic serial_peripheral_enable_o,          // Enabled
    input wire logic fixed_irq_n_i,                       // Fixed pin
    input wire logic gp_interrupt_one_n_i,                // Pin one
    input wire logic gp_interrupt_two_n_i,                // Pin two
    input wire logic capture_input_pin_i,                 // Capture pin
    input wire logic capture_to_timer_o,                  // To timer
    input wire logic timer_compare_i,                     // From timer
    input wire logic compare_output_pin_o                 // Compare pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Settling guard after each reset release
    // ****************************************
    // Keeps $past from looking into the reset period
    logic [1:0] up_r;
    wire logic up = (up_r == 2'h3);
    wire logic se = serial_peripheral_enable_o;
    wire logic [2:0] pins_n = {gp_interrupt_two_n_i, gp_interrupt_one_n_i, fixed_irq_n_i};

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            up_r <= 2'h0;
        else if (!up)
            up_r <= up_r + 2'h1;
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    AST_WAIT_PULSE: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_PORT_HOLD: assert property (up && !$past(write && !waitrequest) |->
        $stable(port_pin_o) && $stable(port_pin_oe_o))
        else $error("port latch or direction changed without a write");
    AST_SERIAL_GATE: assert property (up && !se && !$past(se) |->
        fixed_port_serial_lines_oe_o == '0 && fixed_port_serial_lines_o == '0)
        else $error("serial drivers active while serial disabled");
    AST_SERIAL_PASS: assert property (up && se && $past(se) |->
        {fixed_port_serial_lines_o, fixed_port_serial_lines_oe_o} == $past(serial_drive_i))
        else $error("serial drive not passed to the fixed port");
    AST_SERIAL_SYNC: assert property (up |->
        serial_lines_in_o == $past(fixed_port_serial_lines_i, 2))
        else $error("serial input lines not two cycles behind the pins");
    AST_CAPTURE_SYNC: assert property (up |->
        capture_to_timer_o == $past(capture_input_pin_i, 2))
        else $error("capture level not two cycles behind the pin");
    AST_COMPARE_FOLLOW: assert property (up |->
        compare_output_pin_o == $past(timer_compare_i))
        else $error("compare pin not one cycle behind the timer");
    AST_IRQ_CAUSE: assert property (up && $rose(irq_o) && !$past(write) |->
        $past(pins_n, 3) != 3'h7)
        else $error("interrupt raised with no pin low three cycles before");

    COV_IRQ: cover property ($rose(irq_o));
    COV_SERIAL: cover property ($rose(se));
    COV_DRIVE: cover property (port_pin_oe_o != '0);
endmodule // pin_function_select_properties

bind pin_function_select pin_function_select_properties #(.PW(PW), .NP(NP)) u_props (
    .ref_clk_i, .reset_n_i, .read, .write, .waitrequest, .irq_o, .port_pin_o, .port_pin_oe_o,
    .fixed_port_serial_lines_i, .fixed_port_serial_lines_o, .fixed_port_serial_lines_oe_o,
    .serial_drive_i, .serial_lines_in_o, .serial_peripheral_enable_o, .fixed_irq_n_i,
    .gp_interrupt_one_n_i, .gp_interrupt_two_n_i, .capture_input_pin_i, .capture_to_timer_o,
    .timer_compare_i, .compare_output_pin_o);

`default_nettype wire

// >>> dv/pin_board_model.sv
// Board model: resolves shared port and serial pins between device and board drivers
`default_nettype none

module pin_board_model
(
    input wire logic [39:0] drv_i,       // Device latches
    input wire logic [39:0] oe_i,        // Device enables
    input wire logic [39:0] board_i,     // Board levels
    output logic [39:0] lvl_o,           // Port pin levels
    input wire logic [3:0] fix_drv_i,    // Serial drive
    input wire logic [3:0] fix_oe_i,     // Serial enables
    input wire logic [3:0] fix_board_i,  // Board levels
    output logic [3:0] fix_lvl_o         // Serial pin levels
);
    timeunit 1ns;
    timeprecision 1ns;
    // Board drivers are weak: device wins where it drives
    assign lvl_o = (drv_i & oe_i) | (board_i & ~oe_i);
    assign fix_lvl_o = (fix_drv_i & fix_oe_i) | (fix_board_i & ~fix_oe_i);
endmodule // pin_board_model

`default_nettype wire

// >>> dv/tb_pin_function_select.sv
// Testbench: scenarios for the pin function block
`default_nettype none

module tb_pin_function_select;
    import pin_function_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rd;
    logic waitrequest, irq, se, conv, cap_out, cmp_out;
    logic [39:0] pin_lvl, pin_drv, pin_oe;
    logic [39:0] board_port = 40'h5A5A5A5A5A;
    logic [3:0] fix_lvl, fix_drv, fix_oe, serial_in;
    logic [3:0] board_fix = 4'h6;
    logic [3:0] board_ana = 4'h3;
    fix_drive_t sdrv = '{out: 4'h9, oe: 4'hC};
    logic [2:0] irq_n = 3'h7;
    logic cap = 1'b0;
    logic cmp = 1'b0;
    int error_cnt = 0;
    int num_checks = 0;

    pin_function_select dut (.ref_clk_i(clk), .reset_n_i(reset_n), .address, .read, .write,
        .writedata, .readdata, .waitrequest, .irq_o(irq), .port_pin_i(pin_lvl),
        .port_pin_o(pin_drv), .port_pin_oe_o(pin_oe), .fixed_port_serial_lines_i(fix_lvl),
        .fixed_port_serial_lines_o(fix_drv), .fixed_port_serial_lines_oe_o(fix_oe),
        .serial_drive_i(sdrv), .serial_lines_in_o(serial_in),
        .serial_peripheral_enable_o(se), .fixed_port_analog_lines_i(board_ana),
        .converter_power_on_o(conv), .fixed_irq_n_i(irq_n[0]), .gp_interrupt_one_n_i(irq_n[1]),
        .gp_interrupt_two_n_i(irq_n[2]), .capture_input_pin_i(cap),
        .capture_to_timer_o(cap_out), .timer_compare_i(cmp), .compare_output_pin_o(cmp_out));

    pin_board_model board (.drv_i(pin_drv), .oe_i(pin_oe), .board_i(board_port),
        .lvl_o(pin_lvl), .fix_drv_i(fix_drv), .fix_oe_i(fix_oe), .fix_board_i(board_fix),
        .fix_lvl_o(fix_lvl));

    // ****************************************
    // Shared tasks
    // ****************************************
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        address <= idx << 2;
        write <= wr;
        read <= !wr;
        writedata <= {24'h0, wd};
        do
        begin
            @(posedge clk);
        end
        while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00);
        chk(what, {32'h0, exp}, {8'h0, rd});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        chk("oe", 0, pin_oe);
        chk("latch", 0, pin_drv);
        chk("irq", 0, irq);
        chk("serial enable", 0, se);
        chk("converter", 0, conv);
        rdchk(8'h0B, 8'h00, "dir E");
    endtask

    task t_ports;
        logic [7:0] dir, lat;
        for (int p = 0; p < 5; p++)
        begin
            // Unbonded fifth port goes fully to output
            dir = (p == 4) ? 8'hFF : 8'hA5;
            lat = 8'h3C ^ 8'(p);
            bus(1'b1, IDX_PORT_DATA_BASE + 8'(p), lat);
            bus(1'b1, IDX_PORT_DIR_BASE + 8'(p), dir);
            tick(3);
            chk("oe", {32'h0, dir}, {32'h0, pin_oe[8*p +: 8]});
            chk("latch", {32'h0, lat}, {32'h0, pin_drv[8*p +: 8]});
            rdchk(8'(p), (lat & dir) | (8'h5A & ~dir), "port read");
            rdchk(IDX_PORT_DIR_BASE + 8'(p), dir, "dir read");
        end
    endtask

    task t_serial;
        rdchk(IDX_FIX_SERIAL_DATA, 8'h06, "serial pins");
        chk("serial oe", 0, fix_oe);
        bus(1'b1, IDX_PERIPH_CTRL, 8'(1 << SERIAL_ENABLE_BIT));
        tick(4);
        chk("serial enable", 1, se);
        chk("serial out", 4'h9, fix_drv);
        chk("serial oe", 4'hC, fix_oe);
        chk("serial in", 4'hA, serial_in);
        bus(1'b1, IDX_PERIPH_CTRL, 8'h00);
        tick(2);
        chk("serial oe", 0, fix_oe);
    endtask

    task t_analog;
        rdchk(IDX_FIX_ANALOG_DATA, 8'h03, "analog pins");
        bus(1'b1, IDX_CONV_CTRL, 8'(1 << CONV_POWER_ON_BIT));
        tick(1);
        chk("converter", 1, conv);
        bus(1'b1, IDX_CONV_CTRL, 8'h00);
        tick(1);
        chk("converter", 0, conv);
    endtask

    // Edge mode sets once per fall, level mode re-sets while low
    task t_irq;
        rdchk(IDX_INT_PIN_LEVEL, 8'h07, "pin levels");
        bus(1'b1, IDX_INT_MASK, 8'h07);
        for (int i = 0; i < 3; i++)
        begin
            for (int m = 0; m < 2; m++)
            begin
                bus(1'b1, IDX_INT_CTRL, 8'h30 | 8'(m << i));
                rdchk(IDX_INT_CTRL, 8'h30 | 8'(m << i), "int ctrl");
                irq_n[i] <= 1'b0;
                tick(5);
                chk("irq raised", 1, irq);
                rdchk(IDX_INT_STATUS, 8'(1 << i), "status set");
                rdchk(IDX_INT_STATUS, 8'(m << i), "status while low");
                irq_n[i] <= 1'b1;
                tick(5);
                bus(1'b0, IDX_INT_STATUS, 8'h00);
                rdchk(IDX_INT_STATUS, 8'h00, "status cleared");
                tick(1);
                chk("irq cleared", 0, irq);
            end
        end
        bus(1'b1, IDX_INT_CTRL, 8'h00);
        irq_n[1] <= 1'b0;
        tick(5);
        rdchk(IDX_INT_STATUS, 8'h00, "disabled input");
        irq_n[1] <= 1'b1;
        bus(1'b1, IDX_INT_MASK, 8'h00);
        irq_n[0] <= 1'b0;
        tick(5);
        chk("masked irq", 0, irq);
        irq_n[0] <= 1'b1;
        rdchk(IDX_INT_STATUS, 8'h01, "masked status");
    endtask

    task t_timer;
        cap <= 1'b1;
        cmp <= 1'b1;
        tick(3);
        chk("capture", 1, cap_out);
        chk("compare", 1, cmp_out);
        cap <= 1'b0;
        cmp <= 1'b0;
        tick(2);
        chk("compare", 0, cmp_out);
        chk("capture", 1, cap_out);
        tick(1);
        chk("capture", 0, cap_out);
    endtask

    task t_reset_mid;
        bus(1'b1, IDX_PORT_DIR_BASE, 8'hFF);
        reset_n <= 1'b0;
        tick(2);
        chk("oe in reset", 0, pin_oe);
        chk("wait in reset", 1, waitrequest);
        reset_n <= 1'b1;
        rdchk(IDX_PORT_DIR_BASE, 8'h00, "dir after reset");
    endtask

    task conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        forever #20 clk = ~clk;
    end

    initial
    begin
        #800000;
        error_cnt++;
        conclude();
    end

    initial
    begin
        tick(2);
        reset_n <= 1'b1;
        t_reset();
        t_ports();
        t_serial();
        t_analog();
        t_irq();
        t_timer();
        t_reset_mid();
        conclude();
    end
endmodule // tb_pin_function_select

`default_nettype wire
